// ==== cmd_pkg.sv ====
// package: command codes, register layouts, reset values and carrier types
`default_nettype none
package cmd_pkg;
   // apb register map
   localparam logic [7:0]  ADDR_CMD      = 8'h00;
   localparam logic [7:0]  ADDR_MASTER   = 8'h04;
   localparam logic [7:0]  ADDR_PTR      = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
   localparam logic [7:0]  ADDR_CNT_SEL  = 8'h10;
   localparam logic [7:0]  ADDR_CNT_VAL  = 8'h14;
   localparam logic [7:0]  ADDR_CNT_MODE = 8'h18;
   localparam logic [7:0]  ADDR_CNT_LOAD = 8'h1c;
   localparam logic [7:0]  ADDR_CNT_HOLD = 8'h20;
   // master mode bit positions
   localparam int          MM_AUTOINC_INHIBIT = 14;
   localparam int          MM_WIDE_BUS        = 13;
   localparam int          MM_DIVIDED_FREQUENCY_PIN_OFF        = 12;
   // counter mode bit position
   localparam int          CM_DIRECTION       = 3;
   // command codes
   localparam logic [7:0]  CMD_SEQ_OFF      = 8'he8;
   localparam logic [7:0]  CMD_SEQ_ON       = 8'he0;
   localparam logic [7:0]  CMD_BUS16        = 8'hef;
   localparam logic [7:0]  CMD_BUS8         = 8'he7;
   localparam logic [7:0]  CMD_DIVIDED_FREQUENCY_PIN_OFF     = 8'hee;
   localparam logic [7:0]  CMD_DIVIDED_FREQUENCY_PIN_ON      = 8'he6;
   localparam logic [7:0]  CMD_PREFETCH_OFF = 8'hf9;
   localparam logic [7:0]  CMD_PREFETCH_ON  = 8'hf8;
   localparam logic [7:0]  CMD_RESET        = 8'hff;
   localparam logic [4:0]  CMD_STEP_PFX     = 5'b11110;
   localparam logic [2:0]  CMD_PTR_PFX      = 3'b000;
   localparam logic [2:0]  CMD_LOAD_PFX     = 3'b010;
   localparam logic [2:0]  GROUP_BAD_A      = 3'b000;
   localparam logic [2:0]  GROUP_BAD_B      = 3'b110;
   // reset values
   localparam logic [15:0] MASTER_RST = 16'h0000;
   localparam logic [15:0] MODE_RST   = 16'h0b00;
   localparam logic [15:0] REG_RST    = 16'h0000;
   localparam int          NUM_CNT    = 5;
   // frequency output divider
   localparam logic [3:0]  DIVIDED_FREQUENCY_PIN_DIV   = 4'h9;

   typedef struct packed {
      logic       byte_sel;
      logic [1:0] element;
      logic [2:0] group;
   } ptr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } cmd_t;
endpackage : cmd_pkg
`default_nettype wire

// ==== counter_cell.sv ====
// one counter: value, mode, load and hold storage with step and load actions
`default_nettype none
module counter_cell
   import cmd_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         i_mclk,
   input  wire logic         i_resetn,
   input  wire logic         i_reset_cmd,
   input  wire logic         i_step,
   input  wire logic         i_load,
   input  wire logic         i_tc_set,
   input  wire logic         i_wr_mode,
   input  wire logic         i_wr_load,
   input  wire logic         i_wr_hold,
   input  wire logic         i_wr_val,
   input  wire logic [W-1:0] i_wdata,
   output logic      [W-1:0] o_count,
   output logic      [W-1:0] o_mode,
   output logic      [W-1:0] o_load,
   output logic      [W-1:0] o_hold,
   output logic              o_armed,
   output logic              o_terminal_count
);
   typedef struct packed {
      logic [W-1:0] count;
      logic [W-1:0] mode;
      logic [W-1:0] load;
      logic [W-1:0] hold;
      logic         armed;
      logic         tc;
   } cell_t;

   cell_t st_r;
   cell_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (i_wr_mode) begin
         st_nxt.mode = i_wdata;
      end
      if (i_wr_load) begin
         st_nxt.load = i_wdata;
      end
      if (i_wr_hold) begin
         st_nxt.hold = i_wdata;
      end
      if (i_wr_val) begin
         st_nxt.count = i_wdata;
      end
      if (i_tc_set) begin
         st_nxt.tc = 1'b1;
      end
      if (i_step) begin
         // armed state is not consulted on purpose
         if (st_r.mode[CM_DIRECTION]) begin
            st_nxt.count = st_r.count + W'(1);
         end else begin
            st_nxt.count = st_r.count - W'(1);
         end
         st_nxt.tc = 1'b0;
      end
      if (i_load) begin
         st_nxt.count = st_r.load;
         st_nxt.tc    = 1'b0;
      end
      if (i_reset_cmd) begin
         st_nxt.armed = 1'b0;
         st_nxt.mode  = MODE_RST;
         st_nxt.load  = REG_RST;
         st_nxt.hold  = REG_RST;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '{count: '0, mode: MODE_RST, load: REG_RST, hold: REG_RST,
                   armed: 1'b0, tc: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_count          = st_r.count;
   assign o_mode           = st_r.mode;
   assign o_load           = st_r.load;
   assign o_hold           = st_r.hold;
   assign o_armed          = st_r.armed;
   assign o_terminal_count = st_r.tc;
endmodule : counter_cell
`default_nettype wire

// ==== freq_gate.sv ====
// divided frequency output with gate-off hold low
`default_nettype none
module freq_gate
   import cmd_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_resetn,
   input  wire logic i_gate_off,
   output logic      o_pin
);
   typedef struct packed {
      logic [3:0] div;
      logic       tog;
      logic       pin;
   } fg_t;

   fg_t st_r;
   fg_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (st_r.div == DIVIDED_FREQUENCY_PIN_DIV) begin
         st_nxt.div = 4'h0;
         st_nxt.tog = ~st_r.tog;
      end else begin
         st_nxt.div = st_r.div + 4'h1;
      end
      // gating change may cut a half period short: a transient pulse is tolerated
      st_nxt.pin = i_gate_off ? 1'b0 : st_nxt.tog;
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_pin = st_r.pin;
endmodule : freq_gate
`default_nettype wire

// ==== host_apb_model.sv ====
// host processor model: apb master that issues commands and register accesses
`default_nettype none
module host_apb_model
   import cmd_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // ---------------------------------------------------------------
   // one transfer, entered just after a rising edge
   // ---------------------------------------------------------------
   // no cycle count assumed: waits for pready, only the watchdog ends a hang
   task automatic xfer(input  logic        w,
                       input  logic [7:0]  a,
                       input  logic [31:0] d,
                       output logic [31:0] q,
                       output logic        e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      do @(posedge i_mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never reassigns psel in this step
      @(posedge i_mclk);
   endtask : xfer
endmodule : host_apb_model
`default_nettype wire

// ==== timer_chip_global_command_decoder_tb_top.sv ====
// self-checking testbench of the timing controller command decoder
`default_nettype none
module timer_chip_global_command_decoder_tb_top
   import cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        i_mclk = 1'b0;
   logic        i_resetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pin, wide, inhibit, pf_off;
   int          mismatches = 0;
   int          compares = 0;
   logic [31:0] hi;
   logic [7:0]  mcmd [6] = '{CMD_SEQ_OFF, CMD_BUS16, CMD_DIVIDED_FREQUENCY_PIN_OFF, CMD_SEQ_ON, CMD_BUS8,
                             CMD_DIVIDED_FREQUENCY_PIN_ON};
   logic [15:0] mexp [6] = '{16'h40ff, 16'h60ff, 16'h70ff, 16'h30ff, 16'h10ff, 16'h00ff};
   logic [7:0]  junk [5] = '{8'he9, 8'hf0, 8'hf6, 8'hfa, 8'h80};

   always #12.5 i_mclk = ~i_mclk;

   host_apb_model host_u (.i_mclk(i_mclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));

   timer_cmd_decoder dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .o_divided_frequency_pin(pin), .o_wide_bus_select(wide),
      .o_pointer_autoinc_inhibit(inhibit), .o_write_prefetch_off(pf_off));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      host_u.xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      host_u.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk(q, x);
   endtask : rdchk

   task automatic cmd(input logic [7:0] c);
      wr(ADDR_CMD, {24'h000000, c});
   endtask : cmd

   // high cycles of the frequency pin over two full divider periods
   task automatic count_high(output logic [31:0] n);
      n = 32'h0;
      repeat (40) begin
         @(posedge i_mclk);
         n = n + {31'h0, pin};
      end
   endtask : count_high

   task automatic tally_and_finish;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic        e;
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'b1;
      @(posedge i_mclk);
      chk({28'h0, pin, wide, inhibit, pf_off}, 32'h0);
      rdchk(ADDR_MASTER, 32'h0000);
      rdchk(ADDR_CNT_MODE, 32'h0b00);
      $display("test reset done");
      // pointer set first so the reset can be seen to keep it
      cmd(8'h1d);
      // host start-up order: reset, load all, legal pointer
      cmd(CMD_RESET);
      rdchk(ADDR_PTR, 32'h3d);
      cmd(8'h5f);
      cmd(8'h01);
      rdchk(ADDR_PTR, 32'h21);
      cmd(8'h06);
      rdchk(ADDR_PTR, 32'h21);
      cmd(8'h18);
      rdchk(ADDR_PTR, 32'h21);
      cmd(8'h1d);
      rdchk(ADDR_PTR, 32'h3d);
      $display("test pointer done");
      wr(ADDR_MASTER, 32'h00ff);
      for (int i = 0; i < 6; i++) begin
         cmd(mcmd[i]);
         rdchk(ADDR_MASTER, {16'h0, mexp[i]});
         chk({30'h0, inhibit, wide}, {30'h0, mexp[i][14:13]});
      end
      wr(ADDR_MASTER, 32'h7000);
      chk({30'h0, inhibit, wide}, 32'h3);
      rdchk(ADDR_MASTER, 32'h7000);
      $display("test master bits done");
      repeat (3) @(posedge i_mclk);
      count_high(hi);
      chk(hi, 32'd0);
      wr(ADDR_MASTER, 32'h0000);
      repeat (3) @(posedge i_mclk);
      count_high(hi);
      chk(hi, 32'd20);
      $display("test gating done");
      cmd(CMD_PREFETCH_OFF);
      chk({31'h0, pf_off}, 32'h1);
      rdchk(ADDR_STATUS, 32'h400);
      cmd(CMD_SEQ_ON);
      chk({31'h0, pf_off}, 32'h1);
      cmd(CMD_PREFETCH_ON);
      chk({31'h0, pf_off}, 32'h0);
      cmd(CMD_PREFETCH_OFF);
      cmd(CMD_RESET);
      chk({31'h0, pf_off}, 32'h0);
      rdchk(ADDR_PTR, 32'h3d);
      $display("test prefetch done");
      // counters are disarmed after reset, steps must still move them
      for (int n = 1; n <= 5; n++) begin
         wr(ADDR_CNT_SEL, n - 1);
         wr(ADDR_CNT_VAL, 32'h0000);
         wr(ADDR_CNT_MODE, (n % 2) ? 32'h0b08 : 32'h0b00);
         cmd({CMD_STEP_PFX, 3'(n)});
         rdchk(ADDR_CNT_VAL, (n % 2) ? 32'h0001 : 32'h0ffff);
      end
      $display("test step done");
      wr(ADDR_CNT_SEL, 32'h0);
      wr(ADDR_CNT_LOAD, 32'h0077);
      wr(ADDR_CNT_SEL, 32'h2);
      wr(ADDR_CNT_LOAD, 32'h0042);
      cmd({CMD_LOAD_PFX, 5'b00100});
      rdchk(ADDR_CNT_VAL, 32'h0042);
      rdchk(ADDR_STATUS, 32'h0);
      wr(ADDR_CNT_SEL, 32'h0);
      rdchk(ADDR_CNT_VAL, 32'h0001);
      $display("test load done");
      wr(ADDR_MASTER, 32'h1234);
      wr(ADDR_CNT_MODE, 32'h0123);
      wr(ADDR_CNT_HOLD, 32'h5555);
      cmd(CMD_RESET);
      rdchk(ADDR_MASTER, 32'h0000);
      rdchk(ADDR_CNT_MODE, 32'h0b00);
      rdchk(ADDR_CNT_LOAD, 32'h0000);
      rdchk(ADDR_CNT_HOLD, 32'h0000);
      rdchk(ADDR_STATUS, 32'h0);
      rdchk(ADDR_PTR, 32'h3d);
      $display("test master reset done");
      // power-on reset in mid-run clears configuration but keeps the pointer
      wr(ADDR_MASTER, 32'h7000);
      cmd(CMD_PREFETCH_OFF);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_resetn <= 1'b1;
      @(posedge i_mclk);
      chk({28'h0, pin, wide, inhibit, pf_off}, 32'h0);
      rdchk(ADDR_PTR, 32'h3d);
      $display("test power-on reset done");
      wr(ADDR_MASTER, 32'h5000);
      wr(ADDR_CNT_VAL, 32'h0abc);
      foreach (junk[i]) begin
         cmd(junk[i]);
         rdchk(ADDR_MASTER, 32'h5000);
         rdchk(ADDR_PTR, 32'h3d);
         rdchk(ADDR_CNT_VAL, 32'h0abc);
         rdchk(ADDR_STATUS, 32'h0);
      end
      $display("test unknown codes done");
      // unmapped place: refused with error, reads zero
      host_u.xfer(1'b1, 8'h24, 32'hffff, q, e);
      chk({31'h0, e}, 32'h1);
      host_u.xfer(1'b0, 8'h24, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h8000_0000);
      $display("test unmapped done");
      tally_and_finish();
   end

   // whole run is well under a thousand cycles; this is far beyond it
   initial begin
      repeat (20000) @(posedge i_mclk);
      mismatches++;
      tally_and_finish();
   end
endmodule : timer_chip_global_command_decoder_tb_top
`default_nettype wire

// ==== timer_cmd_decoder.sv ====
// command decoder of the five-counter timing controller with apb register access
//
// Behaviour
// - step moves counter by one, down if direction bit clear, up if set
// - step works even when counter is disarmed
// - command 000xxxxx loads element and group fields, sets byte select
// - pointer updates only for legal groups; host avoids 000 and 110
// - single-bit commands touch only the addressed master bit
// - command e8 sets auto-increment inhibit bit 14
// - command e0 clears auto-increment inhibit bit 14
// - command ef sets wide bus bit 13, all 16 lines used
// - command e7 clears bit 13, words move as two bytes on low lines
// - command ee sets bit 12, frequency pin held low
// - command e6 clears bit 12, pin drives divided frequency
// - full master register write also updates bits 14, 13 and 12
// - command f9 disables write prefetch, read prefetch unaffected
// - write prefetch stays off until f8, reset command or power-on reset
// - command ff acts as power-on reset for master register and counter mode, load and hold; counter values and terminal counts are kept
// - no reset touches the data pointer
// - load command ends terminal count
// - load is 010 in bits 7:5 with five-bit counter select mask
`default_nettype none
module timer_cmd_decoder
   import cmd_pkg::*;
#(
   parameter int N = NUM_CNT
) (
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             o_divided_frequency_pin,
   output logic             o_wide_bus_select,
   output logic             o_pointer_autoinc_inhibit,
   output logic             o_write_prefetch_off
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] master;
      ptr_t        ptr;
      logic        prefetch_off;
      logic [2:0]  cnt_sel;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } dec_t;

   dec_t st_r;
   dec_t st_nxt;

   function automatic logic valid_group(input logic [2:0] g);
      valid_group = (g != GROUP_BAD_A) && (g != GROUP_BAD_B);
   endfunction : valid_group

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_CMD) || (a == ADDR_MASTER) || (a == ADDR_PTR) ||
               (a == ADDR_STATUS) || (a == ADDR_CNT_SEL) || (a == ADDR_CNT_VAL) ||
               (a == ADDR_CNT_MODE) || (a == ADDR_CNT_LOAD) || (a == ADDR_CNT_HOLD);
   endfunction : mapped

   // -----------------------------------------------------------------
   // command decode
   // -----------------------------------------------------------------
   logic        acc;
   logic        wr;
   logic        cmd_wr;
   logic [7:0]  code;
   logic        is_reset;
   logic        is_step;
   logic        is_load;
   logic [2:0]  step_num;
   logic [N-1:0] step_vec;
   logic [N-1:0] load_vec;
   logic [N-1:0] sel_vec;
   logic [15:0] cnt_val [N];
   logic [15:0] cnt_mode [N];
   logic [15:0] cnt_load [N];
   logic [15:0] cnt_hold [N];
   logic [N-1:0] armed;
   logic [N-1:0] tc;

   // registered ready: every transfer completes one cycle after its first access cycle
   assign acc      = psel && penable && !st_r.ready;
   assign wr       = acc && pwrite && mapped(paddr);
   assign cmd_wr   = wr && (paddr == ADDR_CMD);
   assign code     = pwdata[7:0];
   assign is_reset = cmd_wr && (code == CMD_RESET);
   assign is_step  = cmd_wr && (code[7:3] == CMD_STEP_PFX);
   assign is_load  = cmd_wr && (code[7:5] == CMD_LOAD_PFX);
   assign step_num = code[2:0];

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_cnt
         assign step_vec[gi] = is_step && (step_num == 3'(gi + 1));
         assign load_vec[gi] = is_load && code[gi];
         assign sel_vec[gi]  = wr && (st_r.cnt_sel == 3'(gi));
         counter_cell #(.W(16)) u_cell (
            .i_mclk           (i_mclk),
            .i_resetn         (i_resetn),
            .i_reset_cmd      (is_reset),
            .i_step           (step_vec[gi]),
            .i_load           (load_vec[gi]),
            .i_tc_set         (1'b0),
            .i_wr_mode        (sel_vec[gi] && paddr == ADDR_CNT_MODE),
            .i_wr_load        (sel_vec[gi] && paddr == ADDR_CNT_LOAD),
            .i_wr_hold        (sel_vec[gi] && paddr == ADDR_CNT_HOLD),
            .i_wr_val         (sel_vec[gi] && paddr == ADDR_CNT_VAL),
            .i_wdata          (pwdata[15:0]),
            .o_count          (cnt_val[gi]),
            .o_mode           (cnt_mode[gi]),
            .o_load           (cnt_load[gi]),
            .o_hold           (cnt_hold[gi]),
            .o_armed          (armed[gi]),
            .o_terminal_count (tc[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   logic [2:0] rsel;
   assign rsel = (st_r.cnt_sel < 3'(N)) ? st_r.cnt_sel : 3'h0;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.ready = acc;
      st_nxt.err   = acc && !mapped(paddr);
      st_nxt.rdata = 32'h0000_0000;
      if (cmd_wr) begin
         // unknown codes fall through with no effect
         case (code)
            CMD_SEQ_OFF:      st_nxt.master[MM_AUTOINC_INHIBIT] = 1'b1;
            CMD_SEQ_ON:       st_nxt.master[MM_AUTOINC_INHIBIT] = 1'b0;
            CMD_BUS16:        st_nxt.master[MM_WIDE_BUS] = 1'b1;
            CMD_BUS8:         st_nxt.master[MM_WIDE_BUS] = 1'b0;
            CMD_DIVIDED_FREQUENCY_PIN_OFF:     st_nxt.master[MM_DIVIDED_FREQUENCY_PIN_OFF] = 1'b1;
            CMD_DIVIDED_FREQUENCY_PIN_ON:      st_nxt.master[MM_DIVIDED_FREQUENCY_PIN_OFF] = 1'b0;
            CMD_PREFETCH_OFF: st_nxt.prefetch_off = 1'b1;
            CMD_PREFETCH_ON:  st_nxt.prefetch_off = 1'b0;
            CMD_RESET: begin
               // pointer left alone so software keeps its place
               st_nxt.master       = MASTER_RST;
               st_nxt.prefetch_off = 1'b0;
            end
            default: begin
               if (code[7:5] == CMD_PTR_PFX && valid_group(code[2:0])) begin
                  st_nxt.ptr.element  = code[4:3];
                  st_nxt.ptr.group    = code[2:0];
                  st_nxt.ptr.byte_sel = 1'b1;
               end
            end
         endcase
      end
      if (wr && paddr == ADDR_MASTER) begin
         st_nxt.master = pwdata[15:0];
      end
      if (wr && paddr == ADDR_CNT_SEL) begin
         st_nxt.cnt_sel = pwdata[2:0];
      end
      if (acc && !pwrite) begin
         case (paddr)
            ADDR_MASTER:   st_nxt.rdata = {16'h0000, st_r.master};
            ADDR_PTR:      st_nxt.rdata = {26'h0, st_r.ptr};
            ADDR_STATUS:   st_nxt.rdata = {16'h0000, 5'h00, st_r.prefetch_off,
                                           5'(armed), 5'(tc)};
            ADDR_CNT_SEL:  st_nxt.rdata = {29'h0, st_r.cnt_sel};
            ADDR_CNT_VAL:  st_nxt.rdata = {16'h0000, cnt_val[rsel]};
            ADDR_CNT_MODE: st_nxt.rdata = {16'h0000, cnt_mode[rsel]};
            ADDR_CNT_LOAD: st_nxt.rdata = {16'h0000, cnt_load[rsel]};
            ADDR_CNT_HOLD: st_nxt.rdata = {16'h0000, cnt_hold[rsel]};
            default:       st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r.master       <= MASTER_RST;
         // pointer has no reset: power-on leaves it as well
         st_r.prefetch_off <= 1'b0;
         st_r.cnt_sel      <= 3'h0;
         st_r.rdata        <= 32'h0000_0000;
         st_r.ready        <= 1'b0;
         st_r.err          <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   freq_gate u_divided_frequency_pin (
      .i_mclk     (i_mclk),
      .i_resetn   (i_resetn),
      .i_gate_off (st_r.master[MM_DIVIDED_FREQUENCY_PIN_OFF]),
      .o_pin      (o_divided_frequency_pin)
   );

   assign prdata                    = st_r.rdata;
   assign pready                    = st_r.ready;
   assign pslverr                   = st_r.err;
   assign o_wide_bus_select         = st_r.master[MM_WIDE_BUS];
   assign o_pointer_autoinc_inhibit = st_r.master[MM_AUTOINC_INHIBIT];
   assign o_write_prefetch_off      = st_r.prefetch_off;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_seq_off;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_SEQ_OFF) |=> o_pointer_autoinc_inhibit;
   endproperty
   a_seq_off: assert property (p_seq_off) else $error("inhibit not set");

   property p_seq_on;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_SEQ_ON) |=> !o_pointer_autoinc_inhibit;
   endproperty
   a_seq_on: assert property (p_seq_on) else $error("inhibit not cleared");

   property p_bus;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_BUS16) |=> o_wide_bus_select && $stable(st_r.ptr);
   endproperty
   a_bus: assert property (p_bus) else $error("wide bus not set");

   property p_bus8;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_BUS8) |=> !o_wide_bus_select;
   endproperty
   a_bus8: assert property (p_bus8) else $error("wide bus not cleared");

   property p_divided_frequency_pin_low;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_DIVIDED_FREQUENCY_PIN_OFF) |=> ##1 !o_divided_frequency_pin;
   endproperty
   a_divided_frequency_pin_low: assert property (p_divided_frequency_pin_low) else $error("pin not held low");

   logic wr_master_any;
   assign wr_master_any = wr && paddr == ADDR_MASTER;

   property p_single_bit;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_DIVIDED_FREQUENCY_PIN_ON && !wr_master_any)
         |=> ({st_r.master[15:13], st_r.master[11:0]} ==
              {$past(st_r.master[15:13]), $past(st_r.master[11:0])});
   endproperty
   a_single_bit: assert property (p_single_bit) else $error("other bits moved");

   property p_prefetch_hold;
      @(posedge i_mclk) disable iff (!i_resetn)
      (o_write_prefetch_off && !(cmd_wr && (code == CMD_PREFETCH_ON || code == CMD_RESET)))
         |=> o_write_prefetch_off;
   endproperty
   a_prefetch_hold: assert property (p_prefetch_hold) else $error("prefetch reenabled");

   property p_reset_ptr;
      @(posedge i_mclk) disable iff (!i_resetn)
      is_reset |=> (st_r.ptr == $past(st_r.ptr)) && (st_r.master == MASTER_RST);
   endproperty
   a_reset_ptr: assert property (p_reset_ptr) else $error("reset touched pointer");

   property p_bad_group;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code[7:5] == CMD_PTR_PFX && !valid_group(code[2:0]))
         |=> $stable(st_r.ptr);
   endproperty
   a_bad_group: assert property (p_bad_group) else $error("illegal group loaded");

   property p_ptr_load;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code[7:5] == CMD_PTR_PFX && valid_group(code[2:0]))
         |=> st_r.ptr.byte_sel && st_r.ptr.group == $past(code[2:0]);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

   property p_divided_frequency_pin_held;
      @(posedge i_mclk) disable iff (!i_resetn)
      (st_r.master[MM_DIVIDED_FREQUENCY_PIN_OFF] && $past(st_r.master[MM_DIVIDED_FREQUENCY_PIN_OFF]))
         |-> !o_divided_frequency_pin;
   endproperty
   a_divided_frequency_pin_held: assert property (p_divided_frequency_pin_held) else $error("pin high while gated");

   // gate open a full cycle: the pin is the divider wave and nothing else
   property p_divided_frequency_pin_on;
      @(posedge i_mclk) disable iff (!i_resetn)
      !$past(st_r.master[MM_DIVIDED_FREQUENCY_PIN_OFF]) |-> (o_divided_frequency_pin == u_divided_frequency_pin.st_r.tog);
   endproperty
   a_divided_frequency_pin_on: assert property (p_divided_frequency_pin_on) else $error("pin not following divider");

   property p_prefetch_off;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code == CMD_PREFETCH_OFF) |=> o_write_prefetch_off;
   endproperty
   a_prefetch_off: assert property (p_prefetch_off) else $error("prefetch not disabled");

   property p_master_wr;
      @(posedge i_mclk) disable iff (!i_resetn)
      wr_master_any |=> (st_r.master == $past(pwdata[15:0]));
   endproperty
   a_master_wr: assert property (p_master_wr) else $error("master write lost");

   // save and disarm families are outside this block and must stay inert
   property p_ignored;
      @(posedge i_mclk) disable iff (!i_resetn)
      (cmd_wr && code[7:6] == 2'h2)
         |=> $stable(st_r.master) && $stable(st_r.ptr) && $stable(st_r.prefetch_off);
   endproperty
   a_ignored: assert property (p_ignored) else $error("ignored code moved state");

   property p_step;
      @(posedge i_mclk) disable iff (!i_resetn)
      step_vec[0] |=> (cnt_val[0] == ($past(cnt_mode[0][CM_DIRECTION])
                                      ? $past(cnt_val[0]) + 16'h0001
                                      : $past(cnt_val[0]) - 16'h0001));
   endproperty
   a_step: assert property (p_step) else $error("step not by one");

   property p_load;
      @(posedge i_mclk) disable iff (!i_resetn)
      load_vec[2] |=> (cnt_val[2] == $past(cnt_load[2])) && !tc[2];
   endproperty
   a_load: assert property (p_load) else $error("load not applied");

   property p_ready_pulse;
      @(posedge i_mclk) disable iff (!i_resetn)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held over");
endmodule : timer_cmd_decoder
`default_nettype wire
